// >>> dtlu_core.sv
// data transfer and load unit: moves, immediates, indirect and direct loads, indirect stores
// Summary of operation
// - register move copies source in one cycle
// - pair copy moves both bytes in one cycle
// - immediate constant written in one cycle
// - first pointer load reads memory, two cycles
// - post-increment reads then bumps the pointer
// - pre-decrement decrements then reads the memory
// - second pointer has all four load modes
// - displacement load adds offset, pointer kept
// - third pointer has all four load modes
// - direct load reads address from instruction
`timescale 1ns/100ps
`include "dtlu_defines.svh"
module dtlu_core
	import dtlu_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        opValid,
	input  wire dtlu_op_e    opKind,
	input  wire dtlu_ptr_e   opPtr,
	input  wire dtlu_mode_e  opMode,
	input  wire logic [4:0]  destReg,
	input  wire logic [4:0]  sourceReg,
	input  wire logic [7:0]  opImm,
	input  wire logic [5:0]  opDisp,
	input  wire logic [15:0] opAddr,
	input  wire logic [7:0]  memRdData,
	output logic             opReady,
	output logic             opDone,
	output logic             memRd,
	output logic             memWr,
	output logic [15:0]      memAddr,
	output logic [7:0]       memWrData,
	output logic             regWr,
	output logic [4:0]       regWrAddr,
	output logic [7:0]       regWrData,
	output logic [7:0]       flagsOut
);
	////////////////////////////////////////////////////////////////////////
	typedef enum logic {ST_IDLE, ST_MEM} dtlu_state_e;

	logic [7:0]   regFile [32];
	logic [7:0]   next_regFile [32];
	dtlu_state_e  state;
	dtlu_state_e  next_state;
	logic         pendLoad;
	logic         next_pendLoad;
	logic [4:0]   pendDest;
	logic [4:0]   next_pendDest;
	logic         next_opReady;
	logic         next_opDone;
	logic         next_memRd;
	logic         next_memWr;
	logic [15:0]  next_memAddr;
	logic [7:0]   next_memWrData;
	logic         next_regWr;
	logic [4:0]   next_regWrAddr;
	logic [7:0]   next_regWrData;
	logic [4:0]   ptrLo;
	logic [15:0]  ptrVal;
	logic [15:0]  ptrInc;
	logic [15:0]  ptrDec;
	logic [15:0]  effAddr;
	logic [15:0]  newPtr;
	logic         ptrUpd;

	////////////////////////////////////////////////////////////////////////
	// pointer formation and effective address
	always_comb begin
		unique case (opPtr)
			PTR_X:   ptrLo = `DTLU_PTR_X_LO;
			PTR_Y:   ptrLo = `DTLU_PTR_Y_LO;
			default: ptrLo = `DTLU_PTR_Z_LO;
		endcase
		ptrVal = {regFile[ptrLo + 5'd1], regFile[ptrLo]};
		ptrInc = ptrVal + 16'h0001;
		ptrDec = ptrVal - 16'h0001;
		newPtr = ptrVal;
		ptrUpd = 1'b0;
		effAddr = ptrVal;
		unique case (opMode)
			MODE_POSTINC: begin
				newPtr = ptrInc;
				ptrUpd = 1'b1;
			end
			MODE_PREDEC: begin
				newPtr = ptrDec;
				ptrUpd = 1'b1;
				effAddr = ptrDec;
			end
			MODE_DISP: begin
				effAddr = ptrVal + {10'h000, opDisp};
			end
			default: begin
				effAddr = ptrVal;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// instruction sequencing; flags are never touched by this group
	always_comb begin
		next_regFile   = regFile;
		next_state     = state;
		next_pendLoad  = 1'b0;
		next_pendDest  = pendDest;
		next_opReady   = 1'b1;
		next_opDone    = 1'b0;
		next_memRd     = 1'b0;
		next_memWr     = 1'b0;
		next_memAddr   = memAddr;
		next_memWrData = memWrData;
		next_regWr     = 1'b0;
		next_regWrAddr = regWrAddr;
		next_regWrData = regWrData;
		unique case (state)
			ST_IDLE: begin
				if (opValid) begin
					unique case (opKind)
						OP_MOVE: begin
							next_regFile[destReg] = regFile[sourceReg];
							next_opDone    = 1'b1;
							next_regWr     = 1'b1;
							next_regWrAddr = destReg;
							next_regWrData = regFile[sourceReg];
						end
						OP_PAIR: begin
							next_regFile[{destReg[4:1], 1'b0}] = regFile[{sourceReg[4:1], 1'b0}];
							next_regFile[{destReg[4:1], 1'b1}] = regFile[{sourceReg[4:1], 1'b1}];
							next_opDone    = 1'b1;
							next_regWr     = 1'b1;
							next_regWrAddr = {destReg[4:1], 1'b0};
							next_regWrData = regFile[{sourceReg[4:1], 1'b0}];
						end
						OP_IMM: begin
							next_regFile[destReg] = opImm;
							next_opDone    = 1'b1;
							next_regWr     = 1'b1;
							next_regWrAddr = destReg;
							next_regWrData = opImm;
						end
						OP_LOAD_IND, OP_STORE_IND: begin
							if (ptrUpd) begin
								next_regFile[ptrLo]        = newPtr[7:0];
								next_regFile[ptrLo + 5'd1] = newPtr[15:8];
							end
							next_memAddr = effAddr;
							next_opReady = 1'b0;
							next_state   = ST_MEM;
							if (opKind == OP_LOAD_IND) begin
								next_memRd    = 1'b1;
								next_pendLoad = 1'b1;
								next_pendDest = destReg;
							end else begin
								next_memWr     = 1'b1;
								next_memWrData = regFile[sourceReg];
							end
						end
						OP_LOAD_DIR: begin
							next_memAddr  = opAddr;
							next_memRd    = 1'b1;
							next_pendLoad = 1'b1;
							next_pendDest = destReg;
							next_opReady  = 1'b0;
							next_state    = ST_MEM;
						end
						default: begin
							next_opReady = 1'b1;
						end
					endcase
				end
			end
			ST_MEM: begin
				if (pendLoad) begin
					next_regFile[pendDest] = memRdData;
					next_regWr     = 1'b1;
					next_regWrAddr = pendDest;
					next_regWrData = memRdData;
				end
				next_opDone = 1'b1;
				next_state  = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++) begin
				regFile[i] <= `DTLU_RST_BYTE;
			end
			state     <= ST_IDLE;
			pendLoad  <= 1'b0;
			pendDest  <= 5'h00;
			opReady   <= 1'b0;
			opDone    <= 1'b0;
			memRd     <= 1'b0;
			memWr     <= 1'b0;
			memAddr   <= `DTLU_RST_ADDR;
			memWrData <= `DTLU_RST_BYTE;
			regWr     <= 1'b0;
			regWrAddr <= 5'h00;
			regWrData <= `DTLU_RST_BYTE;
			flagsOut  <= `DTLU_RST_BYTE;
		end else begin
			regFile   <= next_regFile;
			state     <= next_state;
			pendLoad  <= next_pendLoad;
			pendDest  <= next_pendDest;
			opReady   <= next_opReady;
			opDone    <= next_opDone;
			memRd     <= next_memRd;
			memWr     <= next_memWr;
			memAddr   <= next_memAddr;
			memWrData <= next_memWrData;
			regWr     <= next_regWr;
			regWrAddr <= next_regWrAddr;
			regWrData <= next_regWrData;
			flagsOut  <= flagsOut;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	move_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_MOVE |=> opDone && regWr && regWrAddr == $past(destReg))
		else $error("move did not finish in one cycle");
	pair_copy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_PAIR
		|=> regWrData == regFile[{$past(destReg[4:1]), 1'b0}])
		else $error("pair copy low byte wrong");
	imm_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_IMM |=> regWrData == $past(opImm) && opDone)
		else $error("immediate load wrong");
	load_two_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_LOAD_IND |=> memRd ##1 opDone && regWr)
		else $error("indirect load not two cycles");
	postinc_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_LOAD_IND && opMode == MODE_POSTINC
		|=> memAddr == $past(ptrVal))
		else $error("post-increment read wrong address");
	predec_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_LOAD_IND && opMode == MODE_PREDEC
		|=> memAddr == $past(ptrVal) - 16'h0001)
		else $error("pre-decrement read wrong address");
	disp_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_LOAD_IND && opMode == MODE_DISP
		|=> memAddr == $past(ptrVal) + {10'h000, $past(opDisp)}
		&& {regFile[$past(ptrLo) + 5'd1], regFile[$past(ptrLo)]} == $past(ptrVal))
		else $error("displacement load wrong");
	direct_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_LOAD_DIR |=> memRd && memAddr == $past(opAddr))
		else $error("direct load wrong address");
	store_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_STORE_IND |=> memWr && !memRd ##1 opDone)
		else $error("indirect store wrong");
	flags_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		flagsOut == $past(flagsOut))
		else $error("flags changed");

	////////////////////////////////////////////////////////////////////////
	// register file contents after each kind of write, plus the memory busy window and store data
	move_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_MOVE |=> regFile[$past(destReg)] == $past(regFile[sourceReg]))
		else $error("move data wrong");
	pair_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_PAIR
		|=> regFile[{$past(destReg[4:1]), 1'b1}] == $past(regFile[{sourceReg[4:1], 1'b1}]))
		else $error("pair copy high byte wrong");
	imm_reg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_IMM |=> regFile[$past(destReg)] == $past(opImm))
		else $error("immediate not in register");
	ready_busy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind inside {OP_LOAD_IND, OP_LOAD_DIR, OP_STORE_IND} |=> !opReady ##1 opReady)
		else $error("memory cycle busy window wrong");
	load_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		memRd && pendLoad |=> regWr && regWrData == $past(memRdData))
		else $error("load data not written");
	ptr_second_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_LOAD_IND && opPtr == PTR_Y && opMode == MODE_POSTINC
		|=> {regFile[29], regFile[28]} == $past(ptrVal) + 16'h0001)
		else $error("second pointer not bumped");
	ptr_third_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_LOAD_IND && opPtr == PTR_Z && opMode == MODE_POSTINC
		|=> {regFile[31], regFile[30]} == $past(ptrVal) + 16'h0001)
		else $error("third pointer not bumped");
	predec_wb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind inside {OP_LOAD_IND, OP_STORE_IND} && opMode == MODE_PREDEC
		|=> {regFile[$past(ptrLo) + 5'd1], regFile[$past(ptrLo)]} == $past(ptrVal) - 16'h0001)
		else $error("pre-decrement not written back");
	store_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		opValid && opReady && opKind == OP_STORE_IND
		|=> memWrData == $past(regFile[sourceReg]))
		else $error("store data wrong");
	cov_move_c: cover property (@(posedge core_clk) opValid && opReady && opKind == OP_MOVE);
	cov_postinc_c: cover property (@(posedge core_clk)
		opValid && opReady && opKind == OP_LOAD_IND && opMode == MODE_POSTINC);
	cov_disp_z_c: cover property (@(posedge core_clk)
		opValid && opReady && opMode == MODE_DISP && opPtr == PTR_Z);
	cov_store_c: cover property (@(posedge core_clk) opValid && opReady && opKind == OP_STORE_IND);
	cov_direct_c: cover property (@(posedge core_clk) opValid && opReady && opKind == OP_LOAD_DIR);
endmodule : dtlu_core

// >>> dtlu_defines.svh
// constants of the data transfer and load unit
`ifndef DTLU_DEFINES_SVH
`define DTLU_DEFINES_SVH
`define DTLU_PTR_X_LO    5'd26
`define DTLU_PTR_Y_LO    5'd28
`define DTLU_PTR_Z_LO    5'd30
`define DTLU_RST_BYTE    8'h00
`define DTLU_RST_ADDR    16'h0000
`define DTLU_MOVE_CYCLES 1
`define DTLU_LOAD_CYCLES 2
`endif

// >>> dtlu_pkg.sv
// types of the data transfer and load unit
package dtlu_pkg;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_MOVE,
		OP_PAIR,
		OP_IMM,
		OP_LOAD_IND,
		OP_LOAD_DIR,
		OP_STORE_IND
	} dtlu_op_e;
	typedef enum logic [1:0] {
		PTR_X,
		PTR_Y,
		PTR_Z
	} dtlu_ptr_e;
	typedef enum logic [1:0] {
		MODE_PLAIN,
		MODE_POSTINC,
		MODE_PREDEC,
		MODE_DISP
	} dtlu_mode_e;
endpackage : dtlu_pkg

// >>> dtlu_mem_model.sv
// data memory model that answers the unit's read and write strobes
`timescale 1ns/100ps
module dtlu_mem_model (
	input  wire logic        core_clk,
	input  wire logic        memRd,
	input  wire logic        memWr,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWrData,
	output logic [7:0]       memRdData
);
	logic [7:0] mem [0:65535];
	logic       rdLate;
	logic [7:0] junk;
	initial begin
		for (int a = 0; a < 65536; a++) begin
			mem[a] = a[7:0] ^ a[15:8];
		end
		rdLate = 1'b0;
		junk = 8'h00;
	end
	always @(posedge core_clk) begin
		rdLate <= memRd;
		junk <= junk + 8'h3b;
		if (memWr) begin
			mem[memAddr] <= memWrData;
		end
	end
	// read data only valid around a read, otherwise a churning pattern
	assign memRdData = (memRd | rdLate) ? mem[memAddr] : junk;
endmodule : dtlu_mem_model

// >>> test_data_transfer_load_unit.sv
// self-checking bench of the data transfer and load unit
`timescale 1ns/100ps
module test_data_transfer_load_unit import dtlu_pkg::*;;
	logic core_clk, rst_n, opValid, opReady, opDone, memRd, memWr, regWr;
	dtlu_op_e    opKind;
	dtlu_ptr_e   opPtr, pt;
	dtlu_mode_e  opMode, md;
	logic [4:0]  destReg, sourceReg, regWrAddr, dd;
	logic [7:0]  opImm, memRdData, memWrData, regWrData, flagsOut;
	logic [5:0]  opDisp;
	logic [15:0] opAddr, memAddr;
	logic [7:0]  rf [0:31];
	logic [31:0] rnd;
	int          bad_count, total_checks, cycles;
	dtlu_core i_dtlu_core (.core_clk, .rst_n, .opValid, .opKind, .opPtr, .opMode, .destReg, .sourceReg,
		.opImm, .opDisp, .opAddr, .memRdData, .opReady, .opDone, .memRd, .memWr, .memAddr, .memWrData,
		.regWr, .regWrAddr, .regWrData, .flagsOut);
	dtlu_mem_model i_dtlu_mem_model (.core_clk, .memRd, .memWr, .memAddr, .memWrData, .memRdData);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic logic [15:0] eff(input logic [15:0] p, input dtlu_mode_e m, input logic [5:0] q);
		return m == MODE_PREDEC ? p - 16'h1 : m == MODE_DISP ? p + {10'h0, q} : p;
	endfunction : eff
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic do_op(input dtlu_op_e k, input dtlu_ptr_e t, input dtlu_mode_e m, input logic [4:0] d,
		input logic [4:0] s, input logic [7:0] im, input logic [5:0] q, input logic [15:0] ad);
		int n, lat, lo;
		logic [15:0] p, ea, sa;
		logic [7:0] ed;
		logic rdy, done;
		logic [1:0] strb;
		logic [3:0] xs;
		lo = 26 + 2 * t;
		p = {rf[lo + 1], rf[lo]};
		ea = k == OP_LOAD_DIR ? ad : eff(p, m, q);
		lat = k inside {OP_MOVE, OP_PAIR, OP_IMM} ? 1 : 2;
		ed = k == OP_PAIR ? rf[s & 5'h1e] : k == OP_IMM ? im : k inside {OP_MOVE, OP_STORE_IND} ? rf[s]
			: i_dtlu_mem_model.mem[ea];
		@(posedge core_clk);
		opValid <= 1'b1;
		opKind <= k;
		opPtr <= t;
		opMode <= m;
		destReg <= d;
		sourceReg <= s;
		opImm <= im;
		opDisp <= q;
		opAddr <= ad;
		@(posedge core_clk);
		opValid <= 1'b0;
		n = 0;
		sa = 16'h0;
		rdy = 1'b0;
		strb = 2'b00;
		done = 1'b0;
		// first look is just after the accepting edge, where one-cycle results already stand
		while (!done) begin
			#1;
			n++;
			if (n == 1) begin
				rdy = opReady;
				strb = {memRd, memWr};
			end
			if (memRd || memWr) sa = memAddr;
			done = opDone === 1'b1 || n == 4;
			if (!done) @(posedge core_clk);
		end
		chk(n[15:0], lat[15:0]);
		xs = {lat == 1, 1'b1, k inside {OP_LOAD_IND, OP_LOAD_DIR}, k == OP_STORE_IND};
		chk({12'h0, rdy, opReady, strb}, {12'h0, xs});
		chk({15'h0, regWr}, {15'h0, k != OP_STORE_IND});
		chk({8'h0, flagsOut}, 16'h0);
		if (k == OP_STORE_IND) begin
			chk({8'h0, memWrData}, {8'h0, ed});
		end else begin
			chk({8'h0, regWrData}, {8'h0, ed});
			chk({11'h0, regWrAddr}, {11'h0, k == OP_PAIR ? d & 5'h1e : d});
		end
		if (lat == 2) chk(sa, ea);
		if (k == OP_PAIR) begin
			rf[d & 5'h1e] = rf[s & 5'h1e];
			rf[d | 5'h1] = rf[s | 5'h1];
		end else if (k != OP_STORE_IND) begin
			rf[d] = ed;
		end
		if (k inside {OP_LOAD_IND, OP_STORE_IND})
			{rf[lo + 1], rf[lo]} = m == MODE_POSTINC ? p + 16'h1 : m == MODE_PREDEC ? p - 16'h1 : p;
	endtask : do_op
	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		{rst_n, opValid, destReg, sourceReg, opImm, opDisp, opAddr} = '0;
		opKind = OP_NONE;
		opPtr = PTR_X;
		opMode = MODE_PLAIN;
		rnd = 32'd83741;
		foreach (rf[i]) rf[i] = 8'h00;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		// pointers start at zero: decrement wraps to the top, increment wraps back
		for (int i = 0; i < 3; i++) begin
			do_op(OP_LOAD_IND, dtlu_ptr_e'(i), MODE_PREDEC, 5'd1, 5'd0, 8'h00, 6'h00, 16'h0);
			do_op(OP_LOAD_IND, dtlu_ptr_e'(i), MODE_POSTINC, 5'd2, 5'd0, 8'h00, 6'h00, 16'h0);
		end
		for (int i = 0; i < 400; i++) begin
			rnd = lfsr(rnd);
			md = dtlu_mode_e'(rnd[9:8]);
			pt = dtlu_ptr_e'(rnd[11:10] % 3);
			dd = rnd[31] ? 5'(26 + rnd[14:12] % 6) : 5'(rnd[7:3] % 26);
			if (pt == PTR_X && md == MODE_DISP) md = MODE_PLAIN;
			do_op(dtlu_op_e'(1 + rnd[2:0] % 6), pt, md, rnd[2:0] % 6 == 2 ? dd : 5'(rnd[7:3] % 26),
				5'(rnd[20:16] % 26), rnd[27:20], rnd[29:24], rnd[31:16]);
		end
		tally_and_finish();
	end
endmodule : test_data_transfer_load_unit
